// *** hw/edge_sched_unit.sv ***
// Output unit end: word FIFO, entry queue, time-triggered output stage
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Fill side
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [WIDTH-1:0] s_data,
   // Drain side
   output logic m_valid,
   input wire logic m_ready,
   output logic [WIDTH-1:0] m_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign s_ready = (cnt_q != (AW+1)'(DEPTH));
   assign m_valid = (cnt_q != '0);
   assign m_data = mem_q[rd_q];
   assign push = s_valid && s_ready;
   assign pop = m_valid && m_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= s_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // word_fifo

module edge_sched_unit #(
   parameter int AREA_ENTRIES = edge_sched_pkg::AREA_LARGE,
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Link to head module
   edge_sched_if.unit link,
   // Output pins
   output logic do0,
   output logic do1,
   // Load monitor pins, asynchronous
   input wire logic overload_pin,
   input wire logic short_pin,
   input wire logic overheat_pin,
   // Indicators
   output logic fault_indicator,
   output logic ch0_indicator,
   output logic ch1_indicator
);
   typedef enum logic [1:0] {
      AREA_TAKE = 2'b01,
      AREA_SKIP = 2'b10
   } area_e;

   localparam int SW = edge_sched_pkg::SEQ_W;
   localparam int CW = $clog2(edge_sched_pkg::QUEUE_DEPTH + 1);
   localparam int SLOTS = 2 ** CW;

   area_e area_q;
   logic [31:0] queue_q [SLOTS];
   logic [CW-1:0] head_q;
   logic [CW-1:0] tail_q;
   logic [CW-1:0] count_q;
   logic [CW-1:0] marked_q;
   logic [3:0] slot_q;
   logic [SW-1:0] last_seq_q;
   logic [7:0] sts_code_q;
   logic [31:0] in_area_q;
   logic [2:0] fault_meta_q;
   logic [2:0] fault_sync_q;
   logic f_valid;
   logic f_ready;
   logic [32:0] f_data;
   logic [31:0] word;
   logic [SW-1:0] w_seq;
   logic w_end;
   logic take;
   logic in_range;
   logic dup;
   logic seq_ok;
   logic full;
   logic store;
   logic [31:0] head_word;
   logic fire;
   logic head_end;

   // ****************************************
   // Incoming words
   // ****************************************
   word_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) in_fifo (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .s_valid(link.area_valid),
      .s_ready(link.area_ready),
      .s_data({link.area_last, link.area_word}),
      .m_valid(f_valid),
      .m_ready(f_ready),
      .m_data(f_data)
   );

   assign word = f_data[31:0];
   assign w_seq = word[edge_sched_pkg::SEQ_LSB +: SW];
   assign w_end = word[edge_sched_pkg::SEQ_LSB + edge_sched_pkg::SEQ_END_BIT];
   assign head_word = queue_q[head_q];
   assign head_end = head_word[edge_sched_pkg::SEQ_LSB + edge_sched_pkg::SEQ_END_BIT];
   // Matching happens only on the ticker step, so at most one entry fires per microsecond
   assign fire = link.us_strobe && (count_q != '0)
      && (head_word[edge_sched_pkg::TIME_LSB +: 16] == link.ticker_low);
   // Draining waits on a firing cycle so the queue never pushes and pops at once
   assign f_ready = !fire;
   assign take = f_valid && f_ready;
   assign in_range = (slot_q < 4'(AREA_ENTRIES));
   assign dup = (w_seq == last_seq_q);
   assign seq_ok = (w_seq == edge_sched_pkg::seq_after(last_seq_q));
   assign full = (count_q == CW'(edge_sched_pkg::QUEUE_DEPTH));
   assign store = take && (area_q == AREA_TAKE) && in_range && seq_ok && !full;

   // ****************************************
   // Area walk
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         area_q <= AREA_TAKE;
         slot_q <= '0;
      end else if (take) begin
         if (f_data[32]) begin
            area_q <= AREA_TAKE;
            slot_q <= '0;
         end else begin
            slot_q <= in_range ? slot_q + 4'h1 : slot_q;
            case (area_q)
               AREA_TAKE: begin
                  if (in_range && (seq_ok || dup) && w_end) begin
                     area_q <= AREA_SKIP;
                  end
               end
               AREA_SKIP: area_q <= AREA_SKIP;
               default: area_q <= AREA_TAKE;
            endcase
         end
      end
   end

   // ****************************************
   // Entry queue
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (store) begin
         queue_q[tail_q] <= word;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         head_q <= '0;
         tail_q <= '0;
         count_q <= '0;
         marked_q <= '0;
      end else if (store) begin
         tail_q <= tail_q + 1'b1;
         count_q <= count_q + 1'b1;
         marked_q <= marked_q + CW'(w_end);
      end else if (fire) begin
         head_q <= head_q + 1'b1;
         count_q <= count_q - 1'b1;
         marked_q <= marked_q - CW'(head_end);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         last_seq_q <= '0;
      end else if (store) begin
         last_seq_q <= w_seq;
      end
   end

   // ****************************************
   // Queue status
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sts_code_q <= edge_sched_pkg::STS_EMPTY;
      end else if (take && area_q == AREA_TAKE && in_range && !dup) begin
         if (!seq_ok) begin
            sts_code_q <= edge_sched_pkg::STS_SEQ_ERR;
         end else if (full) begin
            sts_code_q <= edge_sched_pkg::STS_FULL;
         end else begin
            sts_code_q <= edge_sched_pkg::STS_OK;
         end
      end else if (fire && count_q == CW'(1)) begin
         sts_code_q <= edge_sched_pkg::STS_EMPTY;
      end
   end

   // ****************************************
   // Input area
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         in_area_q <= '0;
      end else begin
         in_area_q[edge_sched_pkg::LAST_SEQ_OFS*8 +: 8] <= {edge_sched_pkg::LAST_TAG, last_seq_q};
         // Empty queue shows sequence zero, never an unwritten or stale slot
         in_area_q[edge_sched_pkg::NEXT_SEQ_OFS*8 +: 8] <= {edge_sched_pkg::NEXT_TAG,
            (count_q != '0) ? head_word[edge_sched_pkg::SEQ_LSB +: SW] : {SW{1'b0}}};
         in_area_q[edge_sched_pkg::STATUS_OFS*8 +: 8] <= (marked_q != '0) ?
            (sts_code_q | edge_sched_pkg::STS_MARK) : sts_code_q;
         in_area_q[edge_sched_pkg::COUNT_OFS*8 +: 8] <= 8'(count_q);
      end
   end
   assign link.in_area = in_area_q;

   // ****************************************
   // Output stage
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         do0 <= 1'b0;
         do1 <= 1'b0;
      end else if (fire) begin
         do0 <= head_word[edge_sched_pkg::EN_CH0_BIT] && head_word[edge_sched_pkg::LVL_CH0_BIT];
         do1 <= head_word[edge_sched_pkg::EN_CH1_BIT] && head_word[edge_sched_pkg::LVL_CH1_BIT];
      end
   end

   assign ch0_indicator = do0;
   assign ch1_indicator = do1;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         fault_meta_q <= '0;
         fault_sync_q <= '0;
         fault_indicator <= 1'b0;
      end else begin
         fault_meta_q <= {overheat_pin, short_pin, overload_pin};
         fault_sync_q <= fault_meta_q;
         fault_indicator <= |fault_sync_q;
      end
   end
endmodule // edge_sched_unit

// *** hw/edge_sched_pkg.sv ***
// Shared constants and helpers for the timed two-channel output scheduler
// Operation
// - Output area holds 5 or 15 entries
// - Queue stores at most 31 entries
// - Entry: state, sequence, 16-bit time
// - Full queue refuses further entries
// - Host checks queue status before writing
// - Byte 0: last stored sequence, 01b top
// - Byte 1: next pending sequence, 11b top
// - Status 00h after successful store
// - Status 01h on sequence mismatch
// - Status 02h when queue has nothing new
// - Status 03h when queue full
// - Status ORed 80h while marked entry queued
// - Entries after bit-6 entry are ignored
// - Host marks last entry with bit 6, except when it fills the area's last slot
// - Byte 3 holds queued entry count
// - State bits 4/5 enable channels 1/0
// - State bits 6/7 give levels 1/0
// - Fault indicator on overload, short, overheat
// - Channel indicator follows output level
// - Host numbers from 1, increments mod 64
// - Time compared with ticker low word
package edge_sched_pkg;
   // ****************************************
   // Entry layout
   // ****************************************
   localparam int STATE_LSB = 0;
   localparam int SEQ_LSB = 8;
   localparam int TIME_LSB = 16;
   localparam int SEQ_W = 6;
   localparam int EN_CH1_BIT = 4;
   localparam int EN_CH0_BIT = 5;
   localparam int LVL_CH1_BIT = 6;
   localparam int LVL_CH0_BIT = 7;
   localparam int SEQ_END_BIT = 6;
   // ****************************************
   // Input area layout and codes
   // ****************************************
   localparam int LAST_SEQ_OFS = 0;
   localparam int NEXT_SEQ_OFS = 1;
   localparam int STATUS_OFS = 2;
   localparam int COUNT_OFS = 3;
   localparam logic [1:0] LAST_TAG = 2'h1;
   localparam logic [1:0] NEXT_TAG = 2'h3;
   localparam logic [7:0] STS_OK = 8'h00;
   localparam logic [7:0] STS_SEQ_ERR = 8'h01;
   localparam logic [7:0] STS_EMPTY = 8'h02;
   localparam logic [7:0] STS_FULL = 8'h03;
   localparam logic [7:0] STS_MARK = 8'h80;
   localparam logic [7:0] STS_CODE_MASK = 8'h7f;
   // ****************************************
   // Sizes and timing
   // ****************************************
   localparam int AREA_SMALL = 5;
   localparam int AREA_LARGE = 15;
   localparam int QUEUE_DEPTH = 31;
   localparam int CLK_PERIOD_PS = 8000;
   localparam int TICK_US = 1;
   localparam int TICK_CYCLES = TICK_US * 1000000 / CLK_PERIOD_PS;
   localparam logic [SEQ_W-1:0] SEQ_FIRST = 6'h01;

   // Sequence numbers wrap within six bits
   function automatic logic [SEQ_W-1:0] seq_after(input logic [SEQ_W-1:0] s);
      return s + 6'h01;
   endfunction
endpackage

// *** hw/edge_sched_if.sv ***
// Output area, input area and ticker link between head module and output unit
`timescale 1ns/1ps
interface edge_sched_if;
   logic area_valid;
   logic area_ready;
   logic [31:0] area_word;
   logic area_last;
   logic [31:0] in_area;
   logic us_strobe;
   logic [15:0] ticker_low;

   modport unit (
      input area_valid, area_word, area_last, us_strobe, ticker_low,
      output area_ready, in_area
   );
   modport head (
      output area_valid, area_word, area_last, us_strobe, ticker_low,
      input area_ready, in_area
   );
endinterface

// *** hw/edge_sched_head.sv ***
// Head module end: microsecond ticker, entry numbering and output area writer
`timescale 1ns/1ps
module edge_sched_head #(
   parameter int AREA_ENTRIES = edge_sched_pkg::AREA_LARGE
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Link to output unit
   edge_sched_if.head link,
   // Entry requests from user
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [7:0] req_state,
   input wire logic [15:0] req_time,
   input wire logic req_last,
   // Status to user
   output logic [31:0] unit_status,
   output logic [31:0] ticker
);
   localparam int SW = edge_sched_pkg::SEQ_W;
   logic [6:0] div_q;
   logic [SW-1:0] seq_q;
   logic [3:0] slot_q;
   logic [31:0] word_q;
   logic valid_q;
   logic last_q;
   logic unit_full;
   logic accept;
   logic at_end;

   // ****************************************
   // Microsecond ticker
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         div_q <= '0;
         ticker <= '0;
      end else if (div_q == 7'(edge_sched_pkg::TICK_CYCLES - 1)) begin
         div_q <= '0;
         ticker <= ticker + 32'h1;
      end else begin
         div_q <= div_q + 7'h1;
      end
   end
   assign link.us_strobe = (div_q == '0) && reset_n;
   assign link.ticker_low = ticker[15:0];

   // ****************************************
   // Area writer
   // ****************************************
   // Status is sampled before each entry; a full status code (03h) holds off the request
   assign unit_full = ((link.in_area[edge_sched_pkg::STATUS_OFS*8 +: 8] & edge_sched_pkg::STS_CODE_MASK)
      == edge_sched_pkg::STS_FULL);
   assign req_ready = !valid_q && !unit_full;
   assign accept = req_valid && req_ready;
   assign at_end = req_last || (slot_q == 4'(AREA_ENTRIES - 1));

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         seq_q <= edge_sched_pkg::SEQ_FIRST;
         slot_q <= '0;
         word_q <= '0;
         valid_q <= 1'b0;
         last_q <= 1'b0;
      end else if (accept) begin
         // Sequence byte bit 7 stays zero so the time lands in the upper half
         word_q <= {req_time, 1'h0, at_end && slot_q != 4'(AREA_ENTRIES - 1), seq_q,
            req_state[7:4], 4'h0};
         seq_q <= edge_sched_pkg::seq_after(seq_q);
         slot_q <= at_end ? '0 : slot_q + 4'h1;
         valid_q <= 1'b1;
         last_q <= at_end;
      end else if (link.area_ready) begin
         valid_q <= 1'b0;
      end
   end

   assign link.area_valid = valid_q;
   assign link.area_word = word_q;
   assign link.area_last = last_q;
   assign unit_status = link.in_area;
endmodule // edge_sched_head

// *** test/edge_sched_chk.sv ***
// Concurrent checks on the link between head module and output unit
`timescale 1ns/1ps
module edge_sched_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Link signals
   input wire logic area_valid,
   input wire logic area_ready,
   input wire logic [31:0] area_word,
   input wire logic area_last,
   input wire logic [31:0] in_area,
   input wire logic us_strobe,
   input wire logic [15:0] ticker_low
);
   // ****************************************
   // Link properties
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic [7:0] cnt;
   logic [6:0] code;
   assign cnt = in_area[31:24];
   assign code = in_area[22:16];
   sequence s_stall;
      area_valid && !area_ready;
   endsequence
   sequence s_grow;
      cnt == $past(cnt) + 8'h01;
   endsequence
   a_word_hold: assert property (s_stall |=> area_valid && $stable(area_word) && $stable(area_last))
      else $error("Link word changed while stalled");
   a_state_low: assert property (area_valid |-> area_word[3:0] == 4'h0)
      else $error("Low state bits not zero");
   // The first edge after release still shows the reset image
   a_last_tag: assert property ($past(reset_n) |-> in_area[7:6] == 2'h1)
      else $error("Last stored byte top bits wrong");
   a_next_tag: assert property ($past(reset_n) |-> in_area[15:14] == 2'h3)
      else $error("Next pending byte top bits wrong");
   a_count_cap: assert property (cnt <= 8'h1f)
      else $error("Queue count above limit");
   a_count_step: assert property (cnt == $past(cnt) || cnt == $past(cnt) + 8'h01 || cnt + 8'h01 == $past(cnt))
      else $error("Queue count jumped");
   a_store_ok: assert property (s_grow |-> code == 7'h00)
      else $error("Store without ok status");
   a_empty_code: assert property ($past(cnt) != 8'h00 && cnt == 8'h00 |-> code == 7'h02 && !in_area[23])
      else $error("Drained queue without empty status");
   a_mark_clear: assert property (cnt == 8'h00 |-> !in_area[23])
      else $error("Mark flag with empty queue");
   a_strobe_gap: assert property (us_strobe |=> !us_strobe [*8] ##117 us_strobe)
      else $error("Microsecond strobe spacing wrong");
   a_ticker_step: assert property ($changed(ticker_low) |-> ticker_low == $past(ticker_low) + 16'h0001)
      else $error("Ticker low word skipped");
endmodule // edge_sched_chk

// *** test/test_timed_output_fifo_scheduler.sv ***
// Self-checking bench for head module and output unit joined over the link
`timescale 1ns/1ps
module test_timed_output_fifo_scheduler;
   logic ref_clk;
   logic reset_n;
   logic req_valid;
   logic req_ready;
   logic [7:0] req_state;
   logic [15:0] req_time;
   logic req_last;
   logic [31:0] unit_status;
   logic [31:0] ticker;
   logic do0, do1, fault, ch0, ch1;
   logic [2:0] pins;
   logic [5:0] seq;
   int n_fail = 0;
   int n_compared = 0;
   // Rows: state byte, expected do0, expected do1
   localparam logic [9:0] rows [7] = '{{8'hf0, 2'h3}, {8'hc0, 2'h0}, {8'hb0, 2'h2}, {8'h70, 2'h1},
      {8'h90, 2'h0}, {8'he0, 2'h2}, {8'h00, 2'h0}};

   edge_sched_if l1();
   edge_sched_if l2();
   edge_sched_head #(.AREA_ENTRIES(5)) i_edge_sched_head (.ref_clk(ref_clk), .reset_n(reset_n), .link(l1.head),
      .req_valid(req_valid), .req_ready(req_ready), .req_state(req_state), .req_time(req_time),
      .req_last(req_last), .unit_status(unit_status), .ticker(ticker));
   edge_sched_unit #(.AREA_ENTRIES(5), .FIFO_DEPTH(8)) i_edge_sched_unit (.ref_clk(ref_clk), .reset_n(reset_n),
      .link(l1.unit), .do0(do0), .do1(do1), .overload_pin(pins[0]), .short_pin(pins[1]), .overheat_pin(pins[2]),
      .fault_indicator(fault), .ch0_indicator(ch0), .ch1_indicator(ch1));
   // Second unit is fed by the bench so that host faults can be injected
   edge_sched_unit #(.AREA_ENTRIES(15), .FIFO_DEPTH(8)) i_edge_sched_unit_b (.ref_clk(ref_clk), .reset_n(reset_n),
      .link(l2.unit), .do0(), .do1(), .overload_pin(pins[0]), .short_pin(pins[1]), .overheat_pin(pins[2]),
      .fault_indicator(), .ch0_indicator(), .ch1_indicator());
   edge_sched_chk i_edge_sched_chk (.ref_clk(ref_clk), .reset_n(reset_n), .area_valid(l1.area_valid),
      .area_ready(l1.area_ready), .area_word(l1.area_word), .area_last(l1.area_last), .in_area(l1.in_area),
      .us_strobe(l1.us_strobe), .ticker_low(l1.ticker_low));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait, then the compare reports a timeout as a mismatch
   task automatic wait_st(input bit sel, input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (((sel ? l2.in_area : unit_status) & m) !== v && n < 1000);
      chk((sel ? l2.in_area : unit_status) & m, v);
   endtask
   task automatic send(input logic [7:0] st, input logic [15:0] t, input logic lst);
      int n;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_state <= st;
      req_time <= t;
      req_last <= lst;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 1000);
      chk({31'h0, req_ready}, 32'h1);
      @(posedge ref_clk);
      req_valid <= 1'b0;
      seq = seq + 6'h01;
   endtask
   task automatic put(input logic [31:0] w, input logic lst);
      int n;
      @(posedge ref_clk);
      l2.area_valid <= 1'b1;
      l2.area_word <= w;
      l2.area_last <= lst;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (l2.area_ready !== 1'b1 && n < 1000);
      chk({31'h0, l2.area_ready}, 32'h1);
      @(posedge ref_clk);
      l2.area_valid <= 1'b0;
   endtask
   task automatic do_reset();
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      seq = 6'h00;
      wait_st(0, 32'hffffffff, 32'h0002c040);
      chk({30'h0, do0, do1}, 32'h0);
   endtask
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      reset_n = 1'b0;
      req_valid = 1'b0;
      req_state = 8'h00;
      req_time = 16'h0000;
      req_last = 1'b0;
      pins = 3'h0;
      seq = 6'h00;
      l2.area_valid = 1'b0;
      l2.area_word = 32'h0;
      l2.area_last = 1'b0;
      l2.us_strobe = 1'b0;
      l2.ticker_low = 16'h0000;
      do_reset();
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         pins <= 3'h1 << i;
         repeat (5) @(negedge ref_clk);
         chk({31'h0, fault}, 32'h1);
         @(posedge ref_clk);
         pins <= 3'h0;
         repeat (5) @(negedge ref_clk);
         chk({31'h0, fault}, 32'h0);
      end
      for (int i = 0; i < 7; i++) begin
         send(rows[i][9:2], ticker[15:0] + 16'h0003, 1'b1);
         wait_st(0, 32'hffffffff, {16'h0180, 2'h3, seq, 2'h1, seq});
         wait_st(0, 32'hffff00ff, {16'h0002, 8'h00, 2'h1, seq});
         chk({28'h0, do0, do1, ch0, ch1}, {28'h0, rows[i][1:0], rows[i][1:0]});
      end
      do_reset();
      // Far-off times keep the queue from draining while it fills
      for (int i = 0; i < 32; i++) begin
         send(8'h30, ticker[15:0] + 16'h8000, 1'b0);
      end
      // Full areas carry no end mark, so the status has no 80h flag
      wait_st(0, 32'hffffffff, 32'h1f03c15f);
      do_reset();
      put({16'h8000, 8'h02, 8'h30}, 1'b1);
      wait_st(1, 32'hffff0000, 32'h00010000);
      put({16'h8000, 8'h41, 8'h30}, 1'b0);
      put({16'h8000, 8'h02, 8'h30}, 1'b1);
      repeat (8) @(negedge ref_clk);
      wait_st(1, 32'hffffffff, 32'h0180c141);
      finish_test();
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      n_fail++;
      finish_test();
   end
endmodule // test_timed_output_fifo_scheduler
